// *** inc/cabd_defs.vh ***
// constants for the execute-stage alu and branch datapath
`ifndef CABD_DEFS_VH
`define CABD_DEFS_VH

// operation codes
`define CABD_OP_ADD 4'h0
`define CABD_OP_ADD_CY 4'h1
`define CABD_OP_AND 4'h2
`define CABD_OP_SHR_ONE 4'h3
`define CABD_OP_SHR_MULTI 4'h4
`define CABD_OP_BIT_CLR 4'h5
`define CABD_OP_BIT_SET 4'h6
`define CABD_OP_BIT_TGL 4'h7
`define CABD_OP_TEST_SKIP 4'h8
`define CABD_OP_BRC 4'h9
`define CABD_OP_BRU 4'ha
`define CABD_OP_BRW 4'hb
`define CABD_OP_NOP 4'hf

// operand source select
`define CABD_SRC_REG 2'h0
`define CABD_SRC_TEN_LIT 2'h1
`define CABD_SRC_LIT5 2'h2
`define CABD_SRC_FILE 2'h3

// operand size
`define CABD_SZ_WORD 2'h0
`define CABD_SZ_BYTE 2'h1
`define CABD_SZ_DWORD 2'h2

// branch conditions
`define CABD_CC_C 4'h0
`define CABD_CC_NC 4'h1
`define CABD_CC_Z 4'h2
`define CABD_CC_NZ 4'h3
`define CABD_CC_N 4'h4
`define CABD_CC_NN 4'h5
`define CABD_CC_WRAP 4'h6
`define CABD_CC_NWRAP 4'h7
`define CABD_CC_GT 4'h8
`define CABD_CC_GE 4'h9
`define CABD_CC_LT 4'ha
`define CABD_CC_LE 4'hb
`define CABD_CC_GTU 4'hc
`define CABD_CC_GEU 4'hd
`define CABD_CC_LTU 4'he
`define CABD_CC_LEU 4'hf

// literal and address limits, accumulator register number
`define CABD_TEN_LIT_BYTE_MAX 10'h00ff
`define CABD_FILE_ADDR_MAX 13'h1fff
`define CABD_ACC_REG 4'h0

// cycle counts
`define CABD_CYC_ONE 2'h1
`define CABD_CYC_TWO 2'h2
`define CABD_CYC_THREE 2'h3

// status flag reset
`define CABD_FLAGS_RST 5'h00

`endif

// *** hw/cabd_exec.v ***
// execute stage: add, and, shift, bit ops, bit test skip, branches
`timescale 1ns/100ps
`default_nettype none
`include "cabd_defs.vh"

// Behaviour
// - add and add-with-carry in one cycle, updating all five flags
// - single shift sets c,n,wrap,z; multi-bit shifts set only n,z
// - conditional branch one cycle untaken, two taken; others always two
// - sixteen branch conditions evaluated; branches change no flag
// - bit test skip-if-clear: one cycle, or two/three when skipping; no flags
// - bit clear/set/toggle on 4-bit position, one cycle, no flags
// - five status flags; zero is sticky for the carry-in add
// - ten-bit literal capped at 255 in byte mode, 1023 in word mode
// - file address 0000h..1FFFh, working register zero is accumulator
// - word default, byte suffix 8-bit results only in add and single shift; double-word accepted only by multi-bit shift, which still gives a 16-bit result
// - sixteen working registers usable as source, destination or base
module cabd_exec (
    // clock and reset
    input wire clock_in,
    input wire rst_in,
    // instruction
    input wire issue_in,
    input wire [3:0] op_in,
    input wire [1:0] size_in,
    input wire [1:0] src_sel_in,
    input wire [3:0] base_reg_in,
    input wire [3:0] src_reg_in,
    input wire [3:0] dst_reg_in,
    input wire [9:0] ten_bit_literal_in,
    input wire [4:0] lit5_in,
    input wire [3:0] bit_position_field_in,
    input wire [3:0] cond_in,
    input wire to_work_reg_in,
    input wire next_two_word_in,
    // file register operand
    input wire [12:0] file_addr_in,
    input wire [15:0] file_data_in,
    // results
    output reg busy_out,
    output reg done_out,
    output reg [1:0] cycles_out,
    output reg branch_taken_out,
    output reg skip_out,
    output reg file_we_out,
    output reg [12:0] file_addr_out,
    output reg [15:0] file_data_out,
    output reg [15:0] result_out,
    output reg illegal_out,
    // status flags
    output reg carry_flag_out,
    output reg half_carry_flag_out,
    output reg neg_flag_out,
    output reg signed_wrap_flag_out,
    output reg zero_flag_out
);

    reg [15:0] work_reg [0:15];
    reg [1:0] wait_cnt;
    reg [15:0] opa, opb, res;
    reg [31:0] dres;
    reg [16:0] sum;
    reg [8:0] bsum;
    reg c_n, hc_n, n_n, sw_n, z_n;
    reg upd_c, upd_hc, upd_nz, upd_sw;
    reg wr_reg, wr_file, taken, skip, bad;
    reg [1:0] cyc;
    reg [3:0] wdst;
    reg [4:0] shamt;
    reg [15:0] mask;
    integer i;

    function cabd_cond;
        input [3:0] cc;
        input c, z, n, v;
        begin
            case (cc)
                `CABD_CC_C: cabd_cond = c;
                `CABD_CC_NC: cabd_cond = ~c;
                `CABD_CC_Z: cabd_cond = z;
                `CABD_CC_NZ: cabd_cond = ~z;
                `CABD_CC_N: cabd_cond = n;
                `CABD_CC_NN: cabd_cond = ~n;
                `CABD_CC_WRAP: cabd_cond = v;
                `CABD_CC_NWRAP: cabd_cond = ~v;
                `CABD_CC_GT: cabd_cond = ~z & ~(n ^ v);
                `CABD_CC_GE: cabd_cond = ~(n ^ v);
                `CABD_CC_LT: cabd_cond = n ^ v;
                `CABD_CC_LE: cabd_cond = z | (n ^ v);
                `CABD_CC_GTU: cabd_cond = c & ~z;
                `CABD_CC_GEU: cabd_cond = c;
                `CABD_CC_LTU: cabd_cond = ~c;
                default: cabd_cond = ~c | z;
            endcase
        end
    endfunction

    always @*
    begin
        opa = work_reg[`CABD_ACC_REG];
        opb = 16'h0000;
        res = 16'h0000;
        dres = 32'h0000_0000;
        sum = 17'h0_0000;
        bsum = 9'h000;
        c_n = carry_flag_out;
        hc_n = half_carry_flag_out;
        n_n = neg_flag_out;
        sw_n = signed_wrap_flag_out;
        z_n = zero_flag_out;
        upd_c = 1'b0;
        upd_hc = 1'b0;
        upd_nz = 1'b0;
        upd_sw = 1'b0;
        wr_reg = 1'b0;
        wr_file = 1'b0;
        taken = 1'b0;
        skip = 1'b0;
        bad = 1'b0;
        cyc = `CABD_CYC_ONE;
        wdst = dst_reg_in;
        shamt = 5'h00;
        mask = 16'h0001 << bit_position_field_in;
        // operand selection
        case (src_sel_in)
            `CABD_SRC_FILE:
            begin
                opb = file_data_in;
                bad = file_addr_in > `CABD_FILE_ADDR_MAX;
                if (to_work_reg_in)
                    wdst = `CABD_ACC_REG;
            end
            `CABD_SRC_TEN_LIT:
            begin
                opa = work_reg[dst_reg_in];
                opb = {6'h00, ten_bit_literal_in};
                if (size_in == `CABD_SZ_BYTE && ten_bit_literal_in > `CABD_TEN_LIT_BYTE_MAX)
                    bad = 1'b1;
            end
            `CABD_SRC_LIT5:
            begin
                opa = work_reg[base_reg_in];
                opb = {11'h000, lit5_in};
            end
            default:
            begin
                opa = work_reg[base_reg_in];
                opb = work_reg[src_reg_in];
            end
        endcase
        if (size_in == `CABD_SZ_DWORD && op_in != `CABD_OP_SHR_MULTI)
            bad = 1'b1;
        case (op_in)
            `CABD_OP_ADD, `CABD_OP_ADD_CY:
            begin
                upd_c = 1'b1;
                upd_hc = 1'b1;
                upd_nz = 1'b1;
                upd_sw = 1'b1;
                wr_reg = 1'b1;
                sum = {1'b0, opa} + {1'b0, opb} + {16'h0000, (op_in == `CABD_OP_ADD_CY) & carry_flag_out};
                res = sum[15:0];
                hc_n = (opa[3:0] + opb[3:0] + {3'h0, (op_in == `CABD_OP_ADD_CY) & carry_flag_out}) > 5'h0f;
                if (size_in == `CABD_SZ_BYTE)
                begin
                    bsum = {1'b0, opa[7:0]} + {1'b0, opb[7:0]} + {8'h00, (op_in == `CABD_OP_ADD_CY) & carry_flag_out};
                    res = {8'h00, bsum[7:0]};
                    c_n = bsum[8];
                    sw_n = (opa[7] == opb[7]) && (bsum[7] != opa[7]);
                end
                else
                begin
                    c_n = sum[16];
                    sw_n = (opa[15] == opb[15]) && (sum[15] != opa[15]);
                end
            end
            `CABD_OP_AND:
            begin
                upd_nz = 1'b1;
                wr_reg = 1'b1;
                res = opa & opb;
            end
            `CABD_OP_SHR_ONE:
            begin
                upd_c = 1'b1;
                upd_nz = 1'b1;
                upd_sw = 1'b1;
                wr_reg = 1'b1;
                opa = (src_sel_in == `CABD_SRC_FILE) ? file_data_in : work_reg[src_reg_in];
                if (size_in == `CABD_SZ_BYTE)
                    res = {8'h00, opa[7], opa[7:1]};
                else
                    res = {opa[15], opa[15:1]};
                c_n = opa[0];
                sw_n = 1'b0;
            end
            `CABD_OP_SHR_MULTI:
            begin
                upd_nz = 1'b1;
                wr_reg = 1'b1;
                shamt = (src_sel_in == `CABD_SRC_LIT5) ? lit5_in : work_reg[src_reg_in][4:0];
                dres = $signed({{16{work_reg[base_reg_in][15]}}, work_reg[base_reg_in]}) >>> shamt;
                res = dres[15:0];
            end
            `CABD_OP_BIT_CLR, `CABD_OP_BIT_SET, `CABD_OP_BIT_TGL:
            begin
                opa = (src_sel_in == `CABD_SRC_FILE) ? file_data_in : work_reg[src_reg_in];
                wdst = src_reg_in;
                wr_reg = 1'b1;
                if (op_in == `CABD_OP_BIT_CLR)
                    res = opa & ~mask;
                else if (op_in == `CABD_OP_BIT_SET)
                    res = opa | mask;
                else
                    res = opa ^ mask;
            end
            `CABD_OP_TEST_SKIP:
            begin
                opa = (src_sel_in == `CABD_SRC_FILE) ? file_data_in : work_reg[src_reg_in];
                skip = (opa & mask) == 16'h0000;
                if (skip)
                    cyc = next_two_word_in ? `CABD_CYC_THREE : `CABD_CYC_TWO;
            end
            `CABD_OP_BRC:
            begin
                taken = cabd_cond(cond_in, carry_flag_out, zero_flag_out, neg_flag_out, signed_wrap_flag_out);
                if (taken)
                    cyc = `CABD_CYC_TWO;
            end
            `CABD_OP_BRU, `CABD_OP_BRW:
            begin
                taken = 1'b1;
                cyc = `CABD_CYC_TWO;
            end
            default:
            begin
                bad = 1'b0;
            end
        endcase
        if (wr_reg && src_sel_in == `CABD_SRC_FILE && !to_work_reg_in)
        begin
            wr_reg = 1'b0;
            wr_file = 1'b1;
        end
        if (size_in == `CABD_SZ_BYTE)
        begin
            n_n = res[7];
            z_n = res[7:0] == 8'h00;
        end
        else
        begin
            n_n = res[15];
            z_n = res == 16'h0000;
        end
        if (op_in == `CABD_OP_ADD_CY)
            z_n = z_n & zero_flag_out;
    end

    always @(posedge clock_in)
    begin
        if (rst_in)
        begin
            busy_out <= 1'b0;
            done_out <= 1'b0;
            cycles_out <= 2'h0;
            branch_taken_out <= 1'b0;
            skip_out <= 1'b0;
            file_we_out <= 1'b0;
            file_addr_out <= 13'h0000;
            file_data_out <= 16'h0000;
            result_out <= 16'h0000;
            illegal_out <= 1'b0;
            {carry_flag_out, half_carry_flag_out, neg_flag_out, signed_wrap_flag_out, zero_flag_out} <= `CABD_FLAGS_RST;
            wait_cnt <= 2'h0;
            for (i = 0; i < 16; i = i + 1)
                work_reg[i] <= 16'h0000;
        end
        else
        begin
            done_out <= 1'b0;
            branch_taken_out <= 1'b0;
            skip_out <= 1'b0;
            file_we_out <= 1'b0;
            illegal_out <= 1'b0;
            if (wait_cnt != 2'h0)
            begin
                wait_cnt <= wait_cnt - 2'h1;
                if (wait_cnt == 2'h1)
                begin
                    busy_out <= 1'b0;
                    done_out <= 1'b1;
                end
            end
            else if (issue_in && op_in != `CABD_OP_NOP)
            begin
                cycles_out <= cyc;
                if (bad)
                begin
                    illegal_out <= 1'b1;
                    done_out <= 1'b1;
                end
                else
                begin
                    result_out <= res;
                    branch_taken_out <= taken;
                    skip_out <= skip;
                    if (wr_reg)
                        work_reg[wdst] <= res;
                    if (wr_file)
                    begin
                        file_we_out <= 1'b1;
                        file_addr_out <= file_addr_in;
                        file_data_out <= res;
                    end
                    if (upd_c)
                        carry_flag_out <= c_n;
                    if (upd_hc)
                        half_carry_flag_out <= hc_n;
                    if (upd_sw)
                        signed_wrap_flag_out <= sw_n;
                    if (upd_nz)
                    begin
                        neg_flag_out <= n_n;
                        zero_flag_out <= z_n;
                    end
                    if (cyc == `CABD_CYC_ONE)
                        done_out <= 1'b1;
                    else
                    begin
                        busy_out <= 1'b1;
                        wait_cnt <= cyc - 2'h1;
                    end
                end
            end
        end
    end

endmodule // cabd_exec

`default_nettype wire

// *** tb/cabd_exec_assertions.sv ***
// assertion checker for the execute stage ports
`timescale 1ns/100ps
`default_nettype none
`include "cabd_defs.vh"
module cabd_exec_chk (
    // clock and reset
    input wire logic clock_in,
    input wire logic rst_in,
    // instruction
    input wire logic issue_in,
    input wire logic [3:0] op_in,
    input wire logic [1:0] size_in,
    input wire logic [1:0] src_sel_in,
    input wire logic [9:0] ten_bit_literal_in,
    // results
    input wire logic busy_out,
    input wire logic done_out,
    input wire logic [1:0] cycles_out,
    input wire logic branch_taken_out,
    input wire logic [15:0] result_out,
    input wire logic illegal_out,
    // flags
    input wire logic carry_flag_out,
    input wire logic half_carry_flag_out,
    input wire logic neg_flag_out,
    input wire logic signed_wrap_flag_out,
    input wire logic zero_flag_out
);
    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (rst_in);
    logic [4:0] flags;
    logic tk;
    logic add_w;
    assign flags = {carry_flag_out, half_carry_flag_out, neg_flag_out, signed_wrap_flag_out, zero_flag_out};
    assign tk = issue_in && !busy_out;
    assign add_w = tk && op_in == `CABD_OP_ADD && size_in == `CABD_SZ_WORD;

    chk_add_one_cycle: assert property (add_w |=> done_out && !busy_out && cycles_out == 2'h1)
        else $error("add did not finish in one cycle");
    chk_word_nz: assert property (add_w |=> neg_flag_out == result_out[15] && zero_flag_out == (result_out == 0))
        else $error("word add n or z wrong");
    chk_byte_upper: assert property (tk && op_in == `CABD_OP_ADD && size_in == `CABD_SZ_BYTE
        && ten_bit_literal_in <= 10'h00ff |=> result_out[15:8] == 8'h00 && neg_flag_out == result_out[7])
        else $error("byte add upper bits or n wrong");
    chk_lit_cap: assert property (tk && op_in == `CABD_OP_ADD && size_in == `CABD_SZ_BYTE
        && src_sel_in == `CABD_SRC_TEN_LIT && ten_bit_literal_in > 10'h00ff |=> illegal_out && done_out)
        else $error("byte literal above cap not refused");
    chk_cond_cycles: assert property (tk && op_in == `CABD_OP_BRC |=> if (branch_taken_out)
        (busy_out ##1 done_out && cycles_out == 2'h2) else (done_out && cycles_out == 2'h1))
        else $error("conditional branch cycle count wrong");
    chk_jump_two: assert property (tk && op_in == `CABD_OP_BRU |=> busy_out && branch_taken_out
        ##1 done_out && !busy_out && cycles_out == 2'h2)
        else $error("jump not two cycles");
    chk_branch_flags: assert property (tk && op_in inside {`CABD_OP_BRC, `CABD_OP_BRU, `CABD_OP_BRW}
        |=> $stable(flags))
        else $error("branch changed flags");
    chk_bitop_flags: assert property (tk
        && op_in inside {`CABD_OP_BIT_CLR, `CABD_OP_BIT_SET, `CABD_OP_BIT_TGL} |=> $stable(flags) && done_out)
        else $error("bit op changed flags or took long");
    chk_skip_flags: assert property (tk && op_in == `CABD_OP_TEST_SKIP |=> $stable(flags))
        else $error("bit test changed flags");
    chk_shift_multi_keep: assert property (tk && op_in == `CABD_OP_SHR_MULTI
        |=> $stable({carry_flag_out, signed_wrap_flag_out}))
        else $error("multi shift changed c or wrap");
    chk_shift_one_wrap: assert property (tk && op_in == `CABD_OP_SHR_ONE && size_in == `CABD_SZ_WORD
        |=> !signed_wrap_flag_out && neg_flag_out == result_out[15])
        else $error("single shift wrap or n wrong");

    cover property (add_w ##1 carry_flag_out);
    cover property (tk && op_in == `CABD_OP_BRC ##1 branch_taken_out);
    cover property (tk && op_in == `CABD_OP_TEST_SKIP ##1 busy_out);
endmodule // cabd_exec_chk

bind cabd_exec cabd_exec_chk u_chk (.clock_in(clock_in), .rst_in(rst_in), .issue_in(issue_in), .op_in(op_in),
    .size_in(size_in), .src_sel_in(src_sel_in), .ten_bit_literal_in(ten_bit_literal_in),
    .busy_out(busy_out), .done_out(done_out),
    .cycles_out(cycles_out), .branch_taken_out(branch_taken_out), .result_out(result_out),
    .illegal_out(illegal_out), .carry_flag_out(carry_flag_out), .half_carry_flag_out(half_carry_flag_out),
    .neg_flag_out(neg_flag_out), .signed_wrap_flag_out(signed_wrap_flag_out), .zero_flag_out(zero_flag_out));
`default_nettype wire

// *** tb/cabd_exec_tb.sv ***
// self-checking bench for the execute stage
`timescale 1ns/100ps
`default_nettype none
`include "cabd_defs.vh"
module cabd_exec_tb;
    logic clock_in, rst_in, issue_in, to_work_reg_in, next_two_word_in;
    logic [3:0] op_in, base_reg_in, src_reg_in, dst_reg_in, bit_position_field_in, cond_in;
    logic [1:0] size_in, src_sel_in;
    logic [9:0] ten_bit_literal_in;
    logic [4:0] lit5_in;
    logic [12:0] file_addr_in;
    logic [15:0] file_data_in;
    wire busy_out, done_out, branch_taken_out, skip_out, file_we_out, illegal_out;
    wire carry_flag_out, half_carry_flag_out, neg_flag_out, signed_wrap_flag_out, zero_flag_out;
    wire [1:0] cycles_out;
    wire [12:0] file_addr_out;
    wire [15:0] file_data_out, result_out;
    logic tk, sk, il, we;
    integer fail_count = 0;
    integer samples_checked = 0;
    integer cyc = 0;
    cabd_exec dut (.clock_in(clock_in), .rst_in(rst_in), .issue_in(issue_in), .op_in(op_in), .size_in(size_in),
        .src_sel_in(src_sel_in), .base_reg_in(base_reg_in), .src_reg_in(src_reg_in), .dst_reg_in(dst_reg_in),
        .ten_bit_literal_in(ten_bit_literal_in), .lit5_in(lit5_in), .bit_position_field_in(bit_position_field_in),
        .cond_in(cond_in), .to_work_reg_in(to_work_reg_in), .next_two_word_in(next_two_word_in),
        .file_addr_in(file_addr_in), .file_data_in(file_data_in), .busy_out(busy_out), .done_out(done_out),
        .cycles_out(cycles_out), .branch_taken_out(branch_taken_out), .skip_out(skip_out),
        .file_we_out(file_we_out), .file_addr_out(file_addr_out), .file_data_out(file_data_out),
        .result_out(result_out), .illegal_out(illegal_out), .carry_flag_out(carry_flag_out),
        .half_carry_flag_out(half_carry_flag_out), .neg_flag_out(neg_flag_out),
        .signed_wrap_flag_out(signed_wrap_flag_out), .zero_flag_out(zero_flag_out));

    task finish_test;
    begin
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    end
    endtask

    task chk(input string nm, input logic [15:0] g, input logic [15:0] e);
    begin
        samples_checked = samples_checked + 1;
        if (g !== e)
        begin
            fail_count = fail_count + 1;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    end
    endtask

    task fl(input logic [4:0] e);
        chk("flags", {carry_flag_out, half_carry_flag_out, neg_flag_out, signed_wrap_flag_out, zero_flag_out}, e);
    endtask

    // issue one instruction and wait for its completion
    task go(input [3:0] op, input [1:0] sel, input [1:0] sz, input [3:0] s, input [3:0] d, input [9:0] lit);
        integer n;
    begin
        op_in = op;
        src_sel_in = sel;
        size_in = sz;
        base_reg_in = s;
        src_reg_in = s;
        dst_reg_in = d;
        ten_bit_literal_in = lit;
        lit5_in = lit[4:0];
        bit_position_field_in = lit[3:0];
        issue_in = 1'b1;
        @(negedge clock_in);
        issue_in = 1'b0;
        tk = branch_taken_out;
        sk = skip_out;
        il = illegal_out;
        we = file_we_out;
        n = 0;
        while (done_out !== 1'b1 && n < 4)
        begin
            @(negedge clock_in);
            n = n + 1;
        end
    end
    endtask

    // all sixteen conditions against a known flag state {c,hc,n,wrap,z}
    task brs(input logic [4:0] f);
        integer i;
        logic c, z, n, v;
        logic [15:0] t;
    begin
        c = f[4];
        n = f[2];
        v = f[1];
        z = f[0];
        t = {!c || z, !c, c, c && !z, z || n != v, n != v, n == v, !z && n == v, !v, v, !n, n, !z, z, !c, c};
        for (i = 0; i < 16; i = i + 1)
        begin
            cond_in = i[3:0];
            go(`CABD_OP_BRC, `CABD_SRC_REG, `CABD_SZ_WORD, 0, 0, 0);
            chk("taken", tk, t[i]);
            chk("cycles", cycles_out, t[i] ? 16'h0002 : 16'h0001);
            fl(f);
        end
    end
    endtask

    initial
    begin
        clock_in = 1'b0;
        forever #25 clock_in = ~clock_in;
    end

    always @(posedge clock_in)
    begin
        cyc <= cyc + 1;
        if (cyc == 3000)
        begin
            fail_count = fail_count + 1;
            finish_test;
        end
    end

    initial
    begin
        rst_in = 1'b1;
        issue_in = 1'b0;
        op_in = `CABD_OP_NOP;
        {size_in, src_sel_in, base_reg_in, src_reg_in, dst_reg_in, bit_position_field_in, cond_in} = 0;
        {ten_bit_literal_in, lit5_in, to_work_reg_in, next_two_word_in} = 0;
        file_addr_in = 13'h1fff;
        file_data_in = 16'h0005;
        repeat (6) @(negedge clock_in);
        rst_in = 1'b0;
        fl(5'h00);
        go(`CABD_OP_ADD, `CABD_SRC_TEN_LIT, `CABD_SZ_WORD, 0, 1, 10'h3ff);
        chk("result", result_out, 16'h03ff);
        fl(5'h00);
        go(`CABD_OP_BIT_SET, `CABD_SRC_REG, `CABD_SZ_WORD, 2, 0, 10'h00f);
        chk("result", result_out, 16'h8000);
        go(`CABD_OP_ADD, `CABD_SRC_REG, `CABD_SZ_WORD, 2, 3, 0);
        chk("result", result_out, 16'h0000);
        fl(5'h13);
        go(`CABD_OP_ADD_CY, `CABD_SRC_REG, `CABD_SZ_WORD, 3, 5, 0);
        chk("result", result_out, 16'h0001);
        go(`CABD_OP_ADD_CY, `CABD_SRC_REG, `CABD_SZ_WORD, 3, 5, 0);
        fl(5'h00);
        go(`CABD_OP_BIT_TGL, `CABD_SRC_REG, `CABD_SZ_WORD, 2, 0, 10'h00f);
        chk("result", result_out, 16'h0000);
        go(`CABD_OP_BIT_CLR, `CABD_SRC_REG, `CABD_SZ_WORD, 1, 0, 0);
        chk("result", result_out, 16'h03fe);
        go(`CABD_OP_TEST_SKIP, `CABD_SRC_REG, `CABD_SZ_WORD, 1, 0, 0);
        chk("cycles", cycles_out, 16'h0002);
        chk("skip", sk, 1'b1);
        next_two_word_in = 1'b1;
        go(`CABD_OP_TEST_SKIP, `CABD_SRC_REG, `CABD_SZ_WORD, 1, 0, 0);
        chk("cycles", cycles_out, 16'h0003);
        go(`CABD_OP_TEST_SKIP, `CABD_SRC_REG, `CABD_SZ_WORD, 1, 0, 10'h001);
        chk("cycles", {cycles_out, sk}, 16'h0002);
        go(`CABD_OP_ADD, `CABD_SRC_TEN_LIT, `CABD_SZ_BYTE, 0, 1, 10'h100);
        chk("illegal", il, 1'b1);
        go(`CABD_OP_ADD, `CABD_SRC_TEN_LIT, `CABD_SZ_BYTE, 0, 1, 10'h0ff);
        chk("result", result_out, 16'h00fd);
        fl(5'h1c);
        go(`CABD_OP_ADD, `CABD_SRC_REG, `CABD_SZ_DWORD, 1, 1, 0);
        chk("illegal", il, 1'b1);
        go(`CABD_OP_BIT_SET, `CABD_SRC_REG, `CABD_SZ_WORD, 6, 0, 10'h00f);
        go(`CABD_OP_BIT_SET, `CABD_SRC_REG, `CABD_SZ_WORD, 6, 0, 0);
        go(`CABD_OP_SHR_ONE, `CABD_SRC_REG, `CABD_SZ_WORD, 2, 7, 0);
        fl(5'h09);
        go(`CABD_OP_SHR_MULTI, `CABD_SRC_LIT5, `CABD_SZ_WORD, 6, 7, 10'h004);
        chk("result", result_out, 16'hf800);
        fl(5'h0c);
        go(`CABD_OP_SHR_ONE, `CABD_SRC_REG, `CABD_SZ_WORD, 6, 7, 0);
        chk("result", result_out, 16'hc000);
        brs(5'h1c);
        go(`CABD_OP_ADD, `CABD_SRC_REG, `CABD_SZ_WORD, 2, 8, 0);
        brs(5'h01);
        go(`CABD_OP_AND, `CABD_SRC_TEN_LIT, `CABD_SZ_WORD, 0, 1, 10'h00f);
        chk("result", result_out, 16'h000d);
        fl(5'h00);
        go(`CABD_OP_BRU, `CABD_SRC_REG, `CABD_SZ_WORD, 0, 0, 0);
        chk("jump", {tk, cycles_out}, 16'h0006);
        go(`CABD_OP_BRW, `CABD_SRC_REG, `CABD_SZ_WORD, 4, 0, 0);
        chk("cycles", cycles_out, 16'h0002);
        go(`CABD_OP_ADD, `CABD_SRC_FILE, `CABD_SZ_WORD, 0, 0, 0);
        chk("file", {we, file_addr_out}, 16'h3fff);
        chk("file data", file_data_out, 16'h0005);
        to_work_reg_in = 1'b1;
        go(`CABD_OP_ADD, `CABD_SRC_FILE, `CABD_SZ_WORD, 0, 0, 0);
        chk("file we", we, 1'b0);
        go(`CABD_OP_ADD, `CABD_SRC_FILE, `CABD_SZ_WORD, 0, 0, 0);
        chk("result", result_out, 16'h000a);
        finish_test;
    end
endmodule // cabd_exec_tb
`default_nettype wire
